// ---- src/cbs_pkg.sv ----
// Operation
// - Free cycle: one clock, bus idle read
// - Program fetch reads next address, advances
// - Operand read or write moves one byte
// - Push writes one byte at stack pointer
// - Pop reads one byte from stack
// - Vector read from top page, high first
// - Autoincrement mode uses index, then increments
// - Byte offset autoincrement adds offset, then increments
// - Indexed modes add none, byte, word offset
// - Stack modes add byte or word offset
// - Flags register holds V H I N Z C
package cbs_pkg;

	// ****************************************
	// Cycle kinds
	// ****************************************
	typedef enum logic [2:0]
	{
		CBS_CYC_FREE   = 3'h0,
		CBS_CYC_FETCH  = 3'h1,
		CBS_CYC_READ   = 3'h3,
		CBS_CYC_WRITE  = 3'h2,
		CBS_CYC_PUSH   = 3'h6,
		CBS_CYC_POP    = 3'h7,
		CBS_CYC_VECTOR = 3'h5
	} cbs_cycle_t;

	// ****************************************
	// Addressing modes
	// ****************************************
	typedef enum logic [3:0]
	{
		CBS_MODE_IMPLIED    = 4'h0,
		CBS_MODE_LITERAL    = 4'h1,
		CBS_MODE_DIRECT     = 4'h2,
		CBS_MODE_FULL       = 4'h3,
		CBS_MODE_IDX0       = 4'h4,
		CBS_MODE_IDX1       = 4'h5,
		CBS_MODE_IDX2       = 4'h6,
		CBS_MODE_IDX_INC    = 4'h7,
		CBS_MODE_IDX1_INC   = 4'h8,
		CBS_MODE_STK1       = 4'h9,
		CBS_MODE_STK2       = 4'hA
	} cbs_mode_t;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [1:0]
	{
		CBS_ST_IDLE = 2'h0,
		CBS_ST_RUN  = 2'h1,
		CBS_ST_DONE = 2'h3
	} cbs_state_t;

	// ****************************************
	// Widths, constants, flag positions
	// ****************************************
	localparam int            CBS_SEQ_MAX   = 12;
	localparam int            CBS_IDX_W     = 4;
	localparam logic [7:0]    CBS_VEC_PAGE  = 8'hFF;
	localparam logic [15:0]   CBS_ONE       = 16'h0001;
	localparam logic [3:0]    CBS_IDX_ONE   = 4'h1;
	localparam logic [7:0]    CBS_FLAGS_RST = 8'h68;
	localparam int            CBS_FLAG_C    = 0;
	localparam int            CBS_FLAG_Z    = 1;
	localparam int            CBS_FLAG_N    = 2;
	localparam int            CBS_FLAG_I    = 3;
	localparam int            CBS_FLAG_H    = 4;
	localparam int            CBS_FLAG_V    = 7;
	localparam logic [7:0]    CBS_FLAGS_IMP = 8'h9F;

endpackage

// ---- src/cbs_seq_rom.sv ----
`timescale 1ns/1ps
// Registered lookup of the cycle kind at a step of a sequence
module cbs_seq_rom
	import cbs_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic [1:0]           seq_sel,
	input  wire logic [3:0]           step,
	output cbs_pkg::cbs_cycle_t       kind_q,
	output logic      [3:0]           len_q
);

	// ****************************************
	// Sequence table
	// ****************************************
	// Sequence 0: interrupt style entry, 1: load, 2: store, 3: pull
	function automatic cbs_cycle_t kind_at(input logic [1:0] s, input logic [3:0] k);
		cbs_cycle_t r;
		r = CBS_CYC_FETCH;
		case (s)
			2'h0:    r = (k < 4'h5) ? CBS_CYC_PUSH :
				(k < 4'h7) ? CBS_CYC_VECTOR :
				(k == 4'h7) ? CBS_CYC_FREE : CBS_CYC_FETCH;
			2'h1:    r = (k == 4'h0) ? CBS_CYC_READ : CBS_CYC_FETCH;
			2'h2:    r = (k == 4'h0) ? CBS_CYC_WRITE : CBS_CYC_FETCH;
			2'h3:    r = (k == 4'h0) ? CBS_CYC_FREE :
				(k == 4'h1) ? CBS_CYC_POP : CBS_CYC_FETCH;
			default: r = CBS_CYC_FETCH;
		endcase
		return r;
	endfunction

	function automatic logic [3:0] len_of(input logic [1:0] s);
		case (s)
			2'h0:    return 4'hB;
			2'h1:    return 4'h3;
			2'h2:    return 4'h3;
			default: return 4'h3;
		endcase
	endfunction

	// ****************************************
	// Registered read data
	// ****************************************
	always_ff @(posedge clk)
	begin
		kind_q <= kind_at(seq_sel, step);
		len_q  <= len_of(seq_sel);
	end

endmodule

// ---- src/cbs_addr_gen.sv ----
`timescale 1ns/1ps
// Effective address former for the addressing modes
module cbs_addr_gen
	import cbs_pkg::*;
(
	input  cbs_pkg::cbs_mode_t mode,
	input  wire logic [15:0]   index_val,
	input  wire logic [15:0]   stack_val,
	input  wire logic [15:0]   operand,
	output logic      [15:0]   ea,
	output logic               post_inc
);

	// ****************************************
	// Address selection
	// ****************************************
	wire logic [15:0] byte_off = {8'h00, operand[7:0]};

	always_comb
	begin
		ea       = operand;
		post_inc = 1'b0;
		case (mode)
			CBS_MODE_DIRECT:   ea = byte_off;
			CBS_MODE_IDX0:     ea = index_val;
			CBS_MODE_IDX1:     ea = index_val + byte_off;
			CBS_MODE_IDX2:     ea = index_val + operand;
			CBS_MODE_IDX_INC:
			begin
				ea       = index_val;
				post_inc = 1'b1;
			end
			CBS_MODE_IDX1_INC:
			begin
				ea       = index_val + byte_off;
				post_inc = 1'b1;
			end
			CBS_MODE_STK1:     ea = stack_val + byte_off;
			CBS_MODE_STK2:     ea = stack_val + operand;
			default:           ea = operand;
		endcase
	end

endmodule

// ---- src/cbs_sequencer.sv ----
`timescale 1ns/1ps
// Bus cycle sequencer: runs one instruction's cycle list on the system bus
module cbs_sequencer
	import cbs_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 start,
	input  wire logic [1:0]           seq_sel,
	input  cbs_pkg::cbs_mode_t        mode,
	input  wire logic [15:0]          operand,
	input  wire logic [7:0]           wr_data,
	input  wire logic [7:0]           rd_data,
	input  wire logic                 flags_we,
	input  wire logic [7:0]           flags_in,
	output logic      [15:0]          bus_addr,
	output logic      [7:0]           bus_wdata,
	output logic                      bus_rd,
	output logic                      bus_wr,
	output cbs_pkg::cbs_cycle_t       bus_kind,
	output logic      [15:0]          fetch_addr,
	output logic      [15:0]          index_reg,
	output logic      [15:0]          stack_reg,
	output logic      [7:0]           cond_flags_reg,
	output logic      [7:0]           rd_byte,
	output logic                      busy,
	output logic                      done
);

	// ****************************************
	// State
	// ****************************************
	cbs_state_t   state_reg;            // Sequencer state
	logic [3:0]   step_reg;             // Current cycle index
	logic [1:0]   sel_reg;              // Latched sequence choice
	cbs_mode_t    mode_reg;             // Latched addressing mode
	logic [15:0]  opnd_reg;             // Latched operand/offset
	logic [7:0]   wdat_reg;             // Latched write byte
	logic [15:0]  pc_reg;               // Fetch address
	logic [15:0]  hx_reg;               // Index register
	logic [15:0]  sp_reg;               // Stack pointer
	logic [7:0]   ccr_reg;              // Condition flags
	logic [15:0]  addr_reg;             // Bus address out
	logic [7:0]   wout_reg;             // Bus write data out
	logic         rd_reg;               // Read strobe
	logic         wr_reg;               // Write strobe
	cbs_cycle_t   kind_reg;             // Cycle kind out
	logic [7:0]   rbyte_reg;            // Last byte read
	logic         done_reg;             // End of sequence pulse
	logic [7:0]   vec_lo_reg;           // Vector byte selector
	logic         vec_hi_reg;           // Next vector byte is the high one
	logic         vec_bus_hi_reg;       // Bus now carries the high vector byte

	// ****************************************
	// Sub blocks
	// ****************************************
	cbs_cycle_t   rom_kind;             // Kind for this step (registered)
	logic [3:0]   rom_len;              // Length of sequence
	logic [15:0]  ea;                   // Effective address
	logic         post_inc;             // Mode increments the index

	// Table is addressed one step ahead, so its registered kind lines up with step_reg
	wire logic [1:0] sel_next  = (state_reg == CBS_ST_IDLE && start) ? seq_sel : sel_reg;
	wire logic [3:0] step_next = (state_reg == CBS_ST_RUN) ? (step_reg + CBS_IDX_ONE) : 4'h0;

	cbs_seq_rom u_rom
	(
		.clk     (clk),
		.seq_sel (sel_next),
		.step    (step_next),
		.kind_q  (rom_kind),
		.len_q   (rom_len)
	);

	cbs_addr_gen u_agen
	(
		.mode      (mode_reg),
		.index_val (hx_reg),
		.stack_val (sp_reg),
		.operand   (opnd_reg),
		.ea        (ea),
		.post_inc  (post_inc)
	);

	// ****************************************
	// Decode of the current cycle
	// ****************************************
	wire logic running   = (state_reg == CBS_ST_RUN);
	wire logic is_free   = running && (rom_kind == CBS_CYC_FREE);
	wire logic is_fetch  = running && (rom_kind == CBS_CYC_FETCH);
	wire logic is_read   = running && (rom_kind == CBS_CYC_READ);
	wire logic is_write  = running && (rom_kind == CBS_CYC_WRITE);
	wire logic is_push   = running && (rom_kind == CBS_CYC_PUSH);
	wire logic is_pop    = running && (rom_kind == CBS_CYC_POP);
	wire logic is_vec    = running && (rom_kind == CBS_CYC_VECTOR);
	wire logic last_step = running && ((step_reg + CBS_IDX_ONE) == rom_len);
	wire logic [15:0] pop_addr = sp_reg + CBS_ONE;
	wire logic [15:0] vec_addr = {CBS_VEC_PAGE, vec_lo_reg};

	// Address driven for each kind of cycle
	wire logic [15:0] addr_next =
		is_fetch ? pc_reg :
		(is_read || is_write) ? ea :
		is_push ? sp_reg :
		is_pop ? pop_addr :
		is_vec ? vec_addr : pc_reg;

	// ****************************************
	// Sequencer state and step
	// ****************************************
	// Idle waits for start; run walks the table; done lasts one cycle
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg <= CBS_ST_IDLE;
			step_reg  <= 4'h0;
		end
		else
		begin
			case (state_reg)
				CBS_ST_IDLE:
				begin
					step_reg <= 4'h0;
					if (start)
						state_reg <= CBS_ST_RUN;
				end
				CBS_ST_RUN:
				begin
					step_reg <= step_reg + CBS_IDX_ONE;
					if (last_step)
						state_reg <= CBS_ST_DONE;
				end
				CBS_ST_DONE:  state_reg <= CBS_ST_IDLE;
				default:      state_reg <= CBS_ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// Latch the request
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sel_reg  <= 2'h0;
			mode_reg <= CBS_MODE_IMPLIED;
			opnd_reg <= 16'h0000;
			wdat_reg <= 8'h00;
		end
		else if (state_reg == CBS_ST_IDLE && start)
		begin
			sel_reg  <= seq_sel;
			mode_reg <= mode;
			opnd_reg <= operand;
			wdat_reg <= wr_data;
		end
	end

	// ****************************************
	// Bus outputs
	// ****************************************
	// Free cycles show up as reads with no bus need
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			addr_reg <= 16'h0000;
			wout_reg <= 8'h00;
			rd_reg   <= 1'b0;
			wr_reg   <= 1'b0;
			kind_reg <= CBS_CYC_FREE;
		end
		else
		begin
			addr_reg <= addr_next;
			wout_reg <= is_write ? wdat_reg : (is_push ? wdat_reg : 8'h00);
			rd_reg   <= is_free || is_fetch || is_read || is_pop || is_vec;
			wr_reg   <= is_write || is_push;
			kind_reg <= running ? rom_kind : CBS_CYC_FREE;
		end
	end

	// ****************************************
	// Program counter and stack pointer
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pc_reg <= 16'h0000;
			sp_reg <= 16'h00FF;
		end
		else
		begin
			if (is_fetch)
				pc_reg <= pc_reg + CBS_ONE;
			else if (rd_reg && (kind_reg == CBS_CYC_VECTOR))
			begin
				// Vector bytes replace the fetch address, high half first
				if (vec_bus_hi_reg)
					pc_reg <= {rd_data, pc_reg[7:0]};
				else
					pc_reg <= {pc_reg[15:8], rd_data};
			end
			if (is_push)
				sp_reg <= sp_reg - CBS_ONE;
			else if (is_pop)
				sp_reg <= pop_addr;
		end
	end

	// ****************************************
	// Index register
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			hx_reg <= 16'h0000;
		else if ((is_read || is_write) && post_inc)
			hx_reg <= hx_reg + CBS_ONE;
	end

	// ****************************************
	// Vector byte order, high first
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			vec_lo_reg <= 8'hFE;
			vec_hi_reg <= 1'b1;
		end
		else if (is_vec)
		begin
			vec_lo_reg <= vec_lo_reg + 8'h01;
			vec_hi_reg <= 1'b0;
		end
		else if (!running)
		begin
			vec_lo_reg <= 8'hFE;
			vec_hi_reg <= 1'b1;
		end
	end

	// Marks which vector byte the bus shows, so its data lands in the right half
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			vec_bus_hi_reg <= 1'b0;
		else
			vec_bus_hi_reg <= is_vec && vec_hi_reg;
	end

	// ****************************************
	// Read capture of operand and pop bytes
	// ****************************************
	// Fetch and vector bytes are not operands and leave it alone
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rbyte_reg <= 8'h00;
		else if (rd_reg && (kind_reg == CBS_CYC_READ || kind_reg == CBS_CYC_POP))
			rbyte_reg <= rd_data;
	end

	// ****************************************
	// Condition flags
	// ****************************************
	// Unimplemented bits stay one; interrupt mask set by entry sequence
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ccr_reg <= CBS_FLAGS_RST;
		else
		begin
			if (flags_we)
				ccr_reg <= flags_in | ~CBS_FLAGS_IMP;
			// Mask set by a vector cycle wins over a load in the same cycle
			if (is_vec)
				ccr_reg[CBS_FLAG_I] <= 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			done_reg <= 1'b0;
		else
			done_reg <= last_step;
	end

	assign bus_addr       = addr_reg;
	assign bus_wdata      = wout_reg;
	assign bus_rd         = rd_reg;
	assign bus_wr         = wr_reg;
	assign bus_kind       = kind_reg;
	assign fetch_addr     = pc_reg;
	assign index_reg      = hx_reg;
	assign stack_reg      = sp_reg;
	assign cond_flags_reg = ccr_reg;
	assign rd_byte        = rbyte_reg;
	assign busy           = (state_reg != CBS_ST_IDLE);
	assign done           = done_reg;

endmodule

// ---- testbench/cbs_sequencer_assertions.sv ----
`timescale 1ns/1ps
// Protocol checker on the sequencer's bus and status ports
module cbs_sequencer_chk
	import cbs_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          start,
	input  wire logic [15:0]   bus_addr,
	input  wire logic          bus_rd,
	input  wire logic          bus_wr,
	input  cbs_pkg::cbs_cycle_t bus_kind,
	input  wire logic [7:0]    cond_flags_reg,
	input  wire logic          busy,
	input  wire logic          done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ****
	// Vector pair: high byte address first, then low
	// ****
	sequence vec_hi_s;
		bus_kind == CBS_CYC_VECTOR && bus_addr == 16'hFFFE;
	endsequence
	sequence vec_lo_s;
		bus_kind == CBS_CYC_VECTOR && bus_addr == 16'hFFFF;
	endsequence
	// ****
	// Cycle kind, flag, start and done checks
	// ****
	chk_free_no_write: assert property (bus_kind == CBS_CYC_FREE |-> !bus_wr)
		else $error("write strobe in a free cycle");
	chk_read_kinds: assert property (bus_kind inside {CBS_CYC_FETCH, CBS_CYC_READ,
		CBS_CYC_POP, CBS_CYC_VECTOR} |-> bus_rd && !bus_wr)
		else $error("read kind without read strobe");
	chk_write_kinds: assert property (bus_kind inside {CBS_CYC_WRITE, CBS_CYC_PUSH}
		|-> bus_wr && !bus_rd)
		else $error("write kind without write strobe");
	chk_fetch_step: assert property (bus_kind == CBS_CYC_FETCH ##1
		bus_kind == CBS_CYC_FETCH |-> bus_addr == $past(bus_addr) + 16'h0001)
		else $error("fetch address not sequential");
	chk_push_step: assert property (bus_kind == CBS_CYC_PUSH ##1
		bus_kind == CBS_CYC_PUSH |-> bus_addr == $past(bus_addr) - 16'h0001)
		else $error("push address not descending");
	chk_vector_page: assert property (bus_kind == CBS_CYC_VECTOR
		|-> bus_addr[15:8] == CBS_VEC_PAGE)
		else $error("vector read off the top page");
	chk_vector_order: assert property (bus_kind == CBS_CYC_VECTOR
		&& $past(bus_kind) != CBS_CYC_VECTOR |-> vec_hi_s ##1 vec_lo_s)
		else $error("vector bytes out of order");
	chk_flags_fixed: assert property (cond_flags_reg[6:5] == 2'h3)
		else $error("unused flag bits not one");
	chk_start_busy: assert property (start && !busy |=> busy)
		else $error("start not taken");
	chk_done_once: assert property (done |=> !done)
		else $error("done longer than one cycle");
	chk_run_bound: assert property ($rose(busy) |-> ##[1:20] done)
		else $error("sequence did not finish");
endmodule

bind cbs_sequencer cbs_sequencer_chk i_cbs_sequencer_chk (.clk(clk), .rst_n(rst_n),
	.start(start), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
	.bus_kind(bus_kind), .cond_flags_reg(cond_flags_reg), .busy(busy), .done(done));

// ---- testbench/cbs_mem_model.sv ----
`timescale 1ns/1ps
// Program and data memory on the system bus
module cbs_mem_model
(
	input  wire logic        clk,
	input  wire logic [15:0] bus_addr,
	input  wire logic [7:0]  bus_wdata,
	input  wire logic        bus_rd,
	input  wire logic        bus_wr,
	output logic      [7:0]  rd_data
);
	logic [7:0] mem [0:65535]; // Byte storage
	logic [7:0] last_q;        // Last byte returned
	// Fill with low byte xor high byte of the address
	initial
	begin
		for (int a = 0; a < 65536; a++)
			mem[a] = 8'(a) ^ 8'(a >> 8);
		last_q = 8'h00;
	end
	// Store written bytes, remember what was read
	always @(posedge clk)
	begin
		if (bus_wr)
			mem[bus_addr] <= bus_wdata;
		if (bus_rd)
			last_q <= rd_data;
	end
	// Data only while read, inverted leftover otherwise
	assign rd_data = bus_rd ? mem[bus_addr] : ~last_q;
endmodule

// ---- testbench/cpu_bus_cycle_sequencer_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the bus cycle sequencer
module cpu_bus_cycle_sequencer_tb;
	import cbs_pkg::*;
	logic clk, rst_n, start, flags_we, bus_rd, bus_wr, busy, done;
	logic [1:0] seq_sel;
	cbs_mode_t mode;
	cbs_cycle_t bus_kind;
	logic [15:0] operand, bus_addr, fetch_addr, index_reg, stack_reg;
	logic [7:0] wr_data, rd_data, flags_in, bus_wdata, cond_flags_reg, rd_byte;
	int mismatches, n_compared;
	int free_reads; // Free cycles seen as reads while busy
	cbs_cycle_t k_q[$]; // Logged non-free kinds
	logic [15:0] a_q[$]; // Their addresses
	logic [7:0] w_q[$];  // Their write data
	cbs_sequencer i_cbs_sequencer (.clk(clk), .rst_n(rst_n), .start(start), .seq_sel(seq_sel),
		.mode(mode), .operand(operand), .wr_data(wr_data), .rd_data(rd_data),
		.flags_we(flags_we), .flags_in(flags_in), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_rd(bus_rd), .bus_wr(bus_wr), .bus_kind(bus_kind), .fetch_addr(fetch_addr),
		.index_reg(index_reg), .stack_reg(stack_reg), .cond_flags_reg(cond_flags_reg),
		.rd_byte(rd_byte), .busy(busy), .done(done));
	cbs_mem_model i_cbs_mem_model (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_rd(bus_rd), .bus_wr(bus_wr), .rd_data(rd_data));
	// ****
	// Helpers
	// ****
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8];
	endfunction
	function automatic logic [15:0] ea_of(input cbs_mode_t m, input logic [15:0] ix, sp, op);
		case (m)
			CBS_MODE_FULL: return op;
			CBS_MODE_DIRECT: return {8'h00, op[7:0]};
			CBS_MODE_IDX0, CBS_MODE_IDX_INC: return ix;
			CBS_MODE_IDX1, CBS_MODE_IDX1_INC: return ix + {8'h00, op[7:0]};
			CBS_MODE_IDX2: return ix + op;
			CBS_MODE_STK1: return sp + {8'h00, op[7:0]};
			default: return sp + op;
		endcase
	endfunction
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Compare logged kinds, first kind in the low bits
	task check_kinds(input int cnt, input logic [29:0] exp);
		check("cycle count", 16'(k_q.size()), 16'(cnt));
		for (int i = 0; i < cnt; i++)
			check("cycle kind", {13'h0, k_q[i]}, {13'h0, exp[3*i +: 3]});
	endtask
	// Start a sequence, hold start for hold cycles, log bus cycles until done
	task run(input logic [1:0] sel, input cbs_mode_t m, input logic [15:0] op, input int hold);
		int n;
		k_q.delete();
		a_q.delete();
		w_q.delete();
		free_reads = 0;
		@(negedge clk);
		seq_sel = sel;
		mode = m;
		operand = op;
		start = 1'b1;
		n = 0;
		while (done !== 1'b1 && n < 40)
		begin
			@(negedge clk);
			n++;
			if (n == hold)
				start = 1'b0;
			if (bus_kind !== CBS_CYC_FREE)
			begin
				k_q.push_back(bus_kind);
				a_q.push_back(bus_addr);
				w_q.push_back(bus_wdata);
			end
			else if (busy === 1'b1 && bus_rd === 1'b1)
				free_reads++;
		end
		start = 1'b0;
		check("done", {15'h0, done}, 16'h0001);
	endtask
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	task test_reset;
		check("pc", fetch_addr, 16'h0000);
		check("sp", stack_reg, 16'h00FF);
		check("index", index_reg, 16'h0000);
		check("flags", {8'h00, cond_flags_reg}, {8'h00, CBS_FLAGS_RST});
		check("busy", {15'h0, busy}, 16'h0000);
		$display("reset test done");
	endtask
	task test_flags;
		logic [7:0] v;
		for (int i = 0; i < 2; i++)
		begin
			v = i ? 8'h00 : CBS_FLAGS_IMP;
			@(negedge clk);
			flags_we = 1'b1;
			flags_in = v;
			@(negedge clk);
			flags_we = 1'b0;
			check("flags load", {8'h00, cond_flags_reg}, {8'h00, v | 8'h60});
		end
		$display("flags test done");
	endtask
	task test_entry;
		wr_data = 8'h5A;
		run(2'h0, CBS_MODE_IMPLIED, 16'h0000, 4); // Start held while busy is ignored
		check_kinds(10, {{3{CBS_CYC_FETCH}}, {2{CBS_CYC_VECTOR}}, {5{CBS_CYC_PUSH}}});
		check("free cycles", 16'(free_reads), 16'h0001);
		for (int i = 0; i < 5; i++)
		begin
			check("push addr", a_q[i], 16'h00FF - 16'(i));
			check("push data", {8'h00, w_q[i]}, 16'h005A);
		end
		check("vector hi", a_q[5], 16'hFFFE);
		check("vector lo", a_q[6], 16'hFFFF);
		check("first fetch", a_q[7], {pat(16'hFFFE), pat(16'hFFFF)});
		check("last fetch", a_q[9], {pat(16'hFFFE), pat(16'hFFFF)} + 16'h0002);
		check("sp after", stack_reg, 16'h00FA);
		check("pc after", fetch_addr, {pat(16'hFFFE), pat(16'hFFFF)} + 16'h0003);
		check("mask", {15'h0, cond_flags_reg[CBS_FLAG_I]}, 16'h0001);
		$display("entry test done");
	endtask
	task test_modes;
		cbs_mode_t m;
		logic [15:0] ix, ea, inc;
		for (int v = 2; v <= 10; v++)
		begin
			m = cbs_mode_t'(v);
			ix = index_reg;
			ea = ea_of(m, ix, stack_reg, 16'h1234);
			inc = (m == CBS_MODE_IDX_INC || m == CBS_MODE_IDX1_INC) ? 16'h0001 : 16'h0000;
			run(2'h1, m, 16'h1234, 1);
			check_kinds(3, {CBS_CYC_FETCH, CBS_CYC_FETCH, CBS_CYC_READ});
			check("read addr", a_q[0], ea);
			check("no free cycle", 16'(free_reads), 16'h0000);
			check("read byte", {8'h00, rd_byte}, {8'h00, pat(ea)});
			check("index after", index_reg, ix + inc);
		end
		$display("modes test done");
	endtask
	task test_store_pull;
		logic [15:0] sp;
		wr_data = 8'hA5;
		run(2'h2, CBS_MODE_FULL, 16'h0321, 1);
		check_kinds(3, {CBS_CYC_FETCH, CBS_CYC_FETCH, CBS_CYC_WRITE});
		check("write addr", a_q[0], 16'h0321);
		check("write data", {8'h00, w_q[0]}, 16'h00A5);
		check("stored", {8'h00, i_cbs_mem_model.mem[16'h0321]}, 16'h00A5);
		sp = stack_reg;
		run(2'h3, CBS_MODE_IMPLIED, 16'h0000, 1);
		check_kinds(2, {CBS_CYC_FETCH, CBS_CYC_POP});
		check("pop addr", a_q[0], sp + 16'h0001);
		check("free read", 16'(free_reads), 16'h0001);
		check("pop byte", {8'h00, rd_byte}, 16'h005A);
		check("sp after pop", stack_reg, sp + 16'h0001);
		$display("store and pull test done");
	endtask
	// ****
	// Clock, watchdog, main sequence
	// ****
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		#(3000 * 40);
		mismatches++;
		give_verdict();
	end
	initial
	begin
		{rst_n, start, flags_we, seq_sel, operand, wr_data, flags_in} = '0;
		mode = CBS_MODE_IMPLIED;
		mismatches = 0;
		n_compared = 0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		test_reset();
		test_flags();
		test_entry();
		test_modes();
		test_store_pull();
		give_verdict();
	end
endmodule
